// ---- core/rate_monitor_defs.vh ----
// constants of the excessive error rate monitor
`ifndef RATE_MONITOR_DEFS_VH
`define RATE_MONITOR_DEFS_VH
// register byte offsets
`define CTRL_OFF        12'h000
`define THRESH_OFF      12'h004
`define STATUS_OFF      12'h008
`define IRQ_STAT_OFF    12'h00c
`define IRQ_MASK_OFF    12'h010
`define COUNT10_OFF     12'h014
`define COUNT60_OFF     12'h018
`define COUNT3I_OFF     12'h01c
// control fields
`define CTRL_ALARM_EN   0
`define CTRL_EDL_EN     1
`define CTRL_MGMT_FDL   2
`define CTRL_NEAR_EN    3
`define CTRL_FAR_EN     4
`define CTRL_RESET      5'h03
// threshold codes
`define THR_E4          3'h0
`define THR_E5          3'h1
`define THR_E6          3'h2
`define THR_E7          3'h3
`define THR_E8          3'h4
`define THR_E9          3'h5
`define THR_RESET       3'h0
// declare limits (count must exceed) and clear limits (count must fall below)
`define DECL_E4         24'd1535
`define CLR_E4          24'd1536
`define DECL_E5         24'd921
`define CLR_E5          24'd922
`define DECL_E6         24'd92
`define CLR_E6          24'd93
`define DECL_E7         24'd9
`define CLR_E7          24'd10
`define DECL_E8         24'd41
`define CLR_E8          24'd42
`define DECL_E9         24'd4
`define CLR_E9          24'd5
// window timing
// 40 bits wide so the 60 s and 15 min products do not wrap at 32 bits
`define CLK_HZ          40'd100000000
`define WIN10_S         10
`define WIN60_S         60
`define INTV_S          900
`define WIN10_CYC       (`WIN10_S * `CLK_HZ)
`define WIN60_CYC       (`WIN60_S * `CLK_HZ)
`define INTV_CYC        (`INTV_S * `CLK_HZ)
// status bits
`define IRQ_DECLARE     0
`define IRQ_CLEAR       1
`endif

// ---- core/window_counter.v ----
// one measurement window: cycle timer plus error count
`timescale 1ns/1ps
module window_counter #(
  parameter [39:0] cycles = 40'd1000
) (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // control
  input  wire        restart,
  input  wire        err,
  // results
  output reg         boundary,
  output reg  [23:0] total,
  output reg  [23:0] running
);
  reg [39:0] tick_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_reg <= 40'h0;
      boundary <= 1'b0;
      total    <= 24'h0;
      running  <= 24'h0;
    end else if (restart) begin
      tick_reg <= 40'h0;
      boundary <= 1'b0;
      total    <= 24'h0;
      running  <= 24'h0;
    end else if (tick_reg == cycles - 40'd1) begin
      // window closes: latch total, restart count
      tick_reg <= 40'h0;
      boundary <= 1'b1;
      total    <= running + {23'h0, err};
      running  <= 24'h0;
    end else begin
      tick_reg <= tick_reg + 40'd1;
      boundary <= 1'b0;
      // running saturates at its maximum; the close adds the last cycle's error without saturation, so total can wrap
      if (err && running != 24'hff_ffff)
        running <= running + 24'd1;
    end
  end
endmodule // window_counter

// ---- core/rate_monitor.v ----
// excessive error rate monitor with apb register file
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`include "rate_monitor_defs.vh"
module rate_monitor #(
  parameter [39:0] win10_cycles = `WIN10_CYC,
  parameter [39:0] win60_cycles = `WIN60_CYC,
  parameter [39:0] intv_cycles  = `INTV_CYC
) (
  // apb
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // framing logic
  input  wire        crc5_err,
  // alarm and interrupt
  output reg         error_rate_alarm,
  output reg         irq
);
  // ****************************************
  // registers
  // ****************************************
  reg  [4:0]  ctrl_reg;
  reg  [2:0]  thresh_reg;
  reg  [1:0]  irq_stat_reg;
  reg  [1:0]  irq_mask_reg;
  reg         cond_reg;
  reg  [23:0] intv0_reg;
  reg  [23:0] intv1_reg;
  reg  [23:0] intv2_reg;
  reg  [23:0] sum3_reg;
  reg         restart_reg;
  wire        b10;
  wire        b60;
  wire        b15;
  wire [23:0] t10;
  wire [23:0] t60;
  wire [23:0] t15;

  wire access   = psel && penable;
  wire wr       = access && pwrite;
  wire rd       = access && !pwrite;
  wire link_ok  = ctrl_reg[`CTRL_EDL_EN] && !ctrl_reg[`CTRL_MGMT_FDL];
  wire alarm_on = link_ok && ctrl_reg[`CTRL_ALARM_EN];
  wire active   = alarm_on && (ctrl_reg[`CTRL_NEAR_EN] || ctrl_reg[`CTRL_FAR_EN]);
  // the whole word is compared so a value above 5 is refused, not folded
  wire thr_wr   = wr && paddr == `THRESH_OFF && pwdata <= {29'h0, `THR_E9};
  // errors are not counted while inactive; enable does not restart the windows or clear their counts
  wire err_in   = crc5_err && active;

  // ****************************************
  // windows
  // ****************************************
  window_counter #(.cycles(win10_cycles)) w10 (
    .pclk     (pclk),
    .presetn  (presetn),
    .restart  (restart_reg),
    .err      (err_in),
    .boundary (b10),
    .total    (t10),
    .running  ()
  );
  window_counter #(.cycles(win60_cycles)) w60 (
    .pclk     (pclk),
    .presetn  (presetn),
    .restart  (restart_reg),
    .err      (err_in),
    .boundary (b60),
    .total    (t60),
    .running  ()
  );
  window_counter #(.cycles(intv_cycles)) w15 (
    .pclk     (pclk),
    .presetn  (presetn),
    .restart  (restart_reg),
    .err      (err_in),
    .boundary (b15),
    .total    (t15),
    .running  ()
  );

  // sliding sum of the last three interval totals
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intv0_reg <= 24'h0;
      intv1_reg <= 24'h0;
      intv2_reg <= 24'h0;
    end else if (restart_reg) begin
      intv0_reg <= 24'h0;
      intv1_reg <= 24'h0;
      intv2_reg <= 24'h0;
    end else if (b15) begin
      intv0_reg <= t15;
      intv1_reg <= intv0_reg;
      intv2_reg <= intv1_reg;
    end
  end

  wire [25:0] sum_wide = {2'b00, intv0_reg} + {2'b00, intv1_reg} + {2'b00, intv2_reg};
  always @* begin
    sum3_reg = (sum_wide[25:24] != 2'b00) ? 24'hff_ffff : sum_wide[23:0];
  end

  // ****************************************
  // per-threshold declare and clear
  // ****************************************
  // each level is evaluated at its own window boundary; lower thresholds
  // include every higher-rate level, so the six flags stack
  reg [5:0] lvl_reg;
  reg [5:0] lvl_next;
  always @* begin
    lvl_next = lvl_reg;
    if (b10) begin
      if (t10 > `DECL_E4)
        lvl_next[0] = 1'b1;
      else if (t10 < `CLR_E4)
        lvl_next[0] = 1'b0;
    end
    if (b60) begin
      if (t60 > `DECL_E5)
        lvl_next[1] = 1'b1;
      else if (t60 < `CLR_E5)
        lvl_next[1] = 1'b0;
      if (t60 > `DECL_E6)
        lvl_next[2] = 1'b1;
      else if (t60 < `CLR_E6)
        lvl_next[2] = 1'b0;
      if (t60 > `DECL_E7)
        lvl_next[3] = 1'b1;
      else if (t60 < `CLR_E7)
        lvl_next[3] = 1'b0;
    end
    if (b15) begin
      if (sum3_reg - intv2_reg + t15 > `DECL_E8)
        lvl_next[4] = 1'b1;
      else if (sum3_reg - intv2_reg + t15 < `CLR_E8)
        lvl_next[4] = 1'b0;
      if (sum3_reg - intv2_reg + t15 > `DECL_E9)
        lvl_next[5] = 1'b1;
      else if (sum3_reg - intv2_reg + t15 < `CLR_E9)
        lvl_next[5] = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      lvl_reg <= 6'h00;
    else if (restart_reg || !active)
      lvl_reg <= 6'h00;
    else
      lvl_reg <= lvl_next;
  end

  // condition under the selected threshold: its own level or any higher rate
  reg cond_next;
  always @* begin
    case (thresh_reg)
      `THR_E4: cond_next = lvl_reg[0];
      `THR_E5: cond_next = |lvl_reg[1:0];
      `THR_E6: cond_next = |lvl_reg[2:0];
      `THR_E7: cond_next = |lvl_reg[3:0];
      `THR_E8: cond_next = |lvl_reg[4:0];
      `THR_E9: cond_next = |lvl_reg[5:0];
      default: cond_next = 1'b0;
    endcase
  end

  // ****************************************
  // control, alarm and interrupt
  // ****************************************
  wire ev_decl = cond_next && !cond_reg;
  wire ev_clr  = !cond_next && cond_reg;
  wire stat_rd = rd && paddr == `IRQ_STAT_OFF;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg         <= `CTRL_RESET;
      thresh_reg       <= `THR_RESET;
      irq_mask_reg     <= 2'b00;
      irq_stat_reg     <= 2'b00;
      cond_reg         <= 1'b0;
      restart_reg      <= 1'b0;
      error_rate_alarm <= 1'b0;
      irq              <= 1'b0;
    end else begin
      restart_reg <= 1'b0;
      if (wr && paddr == `CTRL_OFF)
        ctrl_reg <= pwdata[4:0];
      if (thr_wr) begin
        thresh_reg  <= pwdata[2:0];
        restart_reg <= pwdata[2:0] != thresh_reg;
      end
      if (wr && paddr == `IRQ_MASK_OFF)
        irq_mask_reg <= pwdata[1:0];
      cond_reg <= (thr_wr && pwdata[2:0] != thresh_reg) ? 1'b0 : cond_next;
      // read clears, but a new event in the same cycle is kept
      irq_stat_reg <= (stat_rd ? 2'b00 : irq_stat_reg) | {ev_clr, ev_decl};
      error_rate_alarm <= cond_next && alarm_on;
      irq <= |(((stat_rd ? 2'b00 : irq_stat_reg) | {ev_clr, ev_decl}) & irq_mask_reg);
    end
  end

  // ****************************************
  // apb slave: zero wait states
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (psel && !penable) begin
        if (paddr == `CTRL_OFF)
          prdata <= {27'h0, ctrl_reg};
        else if (paddr == `THRESH_OFF)
          prdata <= {29'h0, thresh_reg};
        else if (paddr == `STATUS_OFF)
          prdata <= {24'h0, lvl_reg, active, cond_reg};
        else if (paddr == `IRQ_STAT_OFF)
          prdata <= {30'h0, irq_stat_reg};
        else if (paddr == `IRQ_MASK_OFF)
          prdata <= {30'h0, irq_mask_reg};
        else if (paddr == `COUNT10_OFF)
          prdata <= {8'h0, t10};
        else if (paddr == `COUNT60_OFF)
          prdata <= {8'h0, t60};
        else if (paddr == `COUNT3I_OFF)
          prdata <= {8'h0, sum3_reg};
        else
          pslverr <= 1'b1;
      end
    end
  end
endmodule // rate_monitor

// ---- bench/rate_monitor_sva.sv ----
// port assertions of the error rate monitor
`timescale 1ns/1ps
module rate_monitor_sva (
  // apb
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // monitor
  input wire        crc5_err,
  input wire        error_rate_alarm,
  input wire        irq
);
  // ****
  // shadow of the written settings
  // ****
  reg  [4:0] ctrl_sh;
  reg  [2:0] thr_sh;
  reg        mask_sh;
  wire       wr = psel & penable & pwrite & pready;
  wire       thr_new = wr & (paddr == 12'h004) & (pwdata < 32'h6) & (pwdata[2:0] != thr_sh);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_sh <= 5'h03;
      thr_sh <= 3'h0;
      mask_sh <= 1'b0;
    end else if (wr) begin
      if (paddr == 12'h000) ctrl_sh <= pwdata[4:0];
      if (thr_new) thr_sh <= pwdata[2:0];
      if (paddr == 12'h010) mask_sh <= pwdata[0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready_one; psel && !penable |=> pready; endproperty
  a_ready_one: assert property (p_ready_one) else $error("no answer after setup");
  property p_ready_access; pready |-> psel && penable; endproperty
  a_ready_access: assert property (p_ready_access) else $error("pready outside access");
  property p_ready_once; pready |=> !pready; endproperty
  a_ready_once: assert property (p_ready_once) else $error("pready held two cycles");
  property p_slverr_map; pready |-> pslverr == (paddr > 12'h01c || paddr[1:0] != 2'b00); endproperty
  a_slverr_map: assert property (p_slverr_map) else $error("pslverr wrong for address");
  property p_prdata_idle; !pready |-> prdata == 32'h0; endproperty
  a_prdata_idle: assert property (p_prdata_idle) else $error("prdata not zero when idle");
  property p_thr_restart; thr_new |-> ##3 !error_rate_alarm [*5]; endproperty
  a_thr_restart: assert property (p_thr_restart) else $error("alarm kept over threshold change");
  // the alarm may only rise while the monitor is active
  property p_alarm_active;
    $rose(error_rate_alarm) |-> ctrl_sh[0] && ctrl_sh[1] && !ctrl_sh[2] && (ctrl_sh[3] || ctrl_sh[4]);
  endproperty
  a_alarm_active: assert property (p_alarm_active) else $error("alarm while inactive");
  property p_irq_mask; !mask_sh && $past(!mask_sh) && $past(!mask_sh, 2) |-> !irq; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
  c_alarm: cover property ($rose(error_rate_alarm));
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (pready && pslverr);
endmodule // rate_monitor_sva
bind rate_monitor rate_monitor_sva chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .crc5_err(crc5_err), .error_rate_alarm(error_rate_alarm), .irq(irq));

// ---- bench/crc_err_source.sv ----
// crc5 error source standing in for the framing logic
`timescale 1ns/1ps
module crc_err_source (
  // clock
  input  wire pclk,
  // error pulses
  output reg  crc5_err
);
  initial crc5_err = 1'b0;
  // an idle cycle between pulses keeps every error a separate event
  task send(input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        @(posedge pclk);
        crc5_err <= 1'b1;
        @(posedge pclk);
        crc5_err <= 1'b0;
      end
    end
  endtask
endmodule // crc_err_source

// ---- bench/excessive_error_rate_monitor_tb.sv ----
// testbench of the excessive error rate monitor
`timescale 1ns/1ps
`include "rate_monitor_defs.vh"
module excessive_error_rate_monitor_tb;
  reg         pclk, presetn, psel, penable, pwrite, err_bit;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire        pready, pslverr, crc5_err, error_rate_alarm, irq;
  integer     fails, checked;
  // short windows: 10 s holds 1536 spaced pulses, 60 s is 4000 cycles and 15 min is 500 cycles
  rate_monitor #(.win10_cycles(40'd3200), .win60_cycles(40'd4000), .intv_cycles(40'd500)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .crc5_err(crc5_err),
    .error_rate_alarm(error_rate_alarm), .irq(irq));
  crc_err_source src_u (.pclk(pclk), .crc5_err(crc5_err));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task wrap_up;
    begin
      if (fails == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (n = 0; pready !== 1'b1 && n < 20; n = n + 1) @(posedge pclk);
      chk("pready", 32'h1, {31'h0, pready});
      rd = prdata;
      err_bit = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task run(input [7:0] ctl, input [2:0] thr, input integer n, input exp);
    integer k;
    begin
      apb(1'b1, `CTRL_OFF, {24'h0, ctl});
      apb(1'b1, `THRESH_OFF, {29'h0, thr ^ 3'h1});
      apb(1'b1, `THRESH_OFF, {29'h0, thr});
      repeat (3) @(negedge pclk);
      chk("alarm after restart", 32'h0, {31'h0, error_rate_alarm});
      src_u.send(n);
      for (k = 0; k < 9000 && error_rate_alarm !== 1'b1; k = k + 1) @(negedge pclk);
      chk("alarm", {31'h0, exp}, {31'h0, error_rate_alarm});
    end
  endtask
  task t_regs;
    begin
      apb(1'b0, `CTRL_OFF, 32'h0);
      chk("ctrl", 32'h3, rd);
      apb(1'b1, `THRESH_OFF, 32'h7);
      apb(1'b0, `THRESH_OFF, 32'h0);
      chk("thresh", 32'h0, rd);
      apb(1'b0, 12'h020, 32'h0);
      chk("pslverr", 32'h1, {31'h0, err_bit});
      apb(1'b1, `IRQ_MASK_OFF, 32'h1);
    end
  endtask
  task t_e7;
    integer k;
    begin
      run(8'h0b, `THR_E7, 9, 1'b0);
      run(8'h0b, `THR_E7, 10, 1'b1);
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'b0, `COUNT60_OFF, 32'h0);
      chk("window count", 32'ha, rd);
      apb(1'b0, `IRQ_STAT_OFF, 32'h0);
      chk("declare event", 32'h1, {31'h0, rd[0]});
      repeat (3) @(negedge pclk);
      chk("irq after read", 32'h0, {31'h0, irq});
      // a clean window must follow before the alarm drops
      for (k = 0; k < 9000 && error_rate_alarm !== 1'b0; k = k + 1) @(negedge pclk);
      chk("alarm cleared", 32'h0, {31'h0, error_rate_alarm});
    end
  endtask
  task t_levels;
    begin
      run(8'h0b, `THR_E4, 1536, 1'b1);
      run(8'h0b, `THR_E9, 4, 1'b0);
      run(8'h0b, `THR_E9, 5, 1'b1);
      run(8'h0b, `THR_E8, 10, 1'b1);
    end
  endtask
  task t_gate;
    begin
      run(8'h0a, `THR_E7, 10, 1'b0);
      run(8'h0f, `THR_E7, 10, 1'b0);
      run(8'h03, `THR_E7, 10, 1'b0);
    end
  endtask
  initial begin
    fails = 0;
    checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_e7;
    t_levels;
    t_gate;
    wrap_up;
  end
  initial begin
    #1000000;
    fails = fails + 1;
    wrap_up;
  end
endmodule // excessive_error_rate_monitor_tb
